// ---- include/carrier_params.svh ----
// Register offsets, field positions and reset values of the carrier selector.
// Assumes inclusion by the design files by bare name.
`ifndef CARRIER_PARAMS_SVH
`define CARRIER_PARAMS_SVH
`define OFS_MOD_CONTROL      2'h0
`define OFS_SOURCE_CONTROL   2'h1
`define OFS_HIGH_CARRIER     2'h2
`define OFS_LOW_CARRIER      2'h3
`define BIT_OUT_DISABLE      7
`define BIT_INVERT           6
`define BIT_SYNC_ENABLE      5
`define MASK_CARRIER         8'hef
`define MASK_SOURCE          8'h8f
`define MASK_CONTROL         8'hf1
`define BIT_MOD_ENABLE       7
`define BIT_SW_MOD_BIT       0
`define RST_REG              8'h00
`define SEL_PIN_ONE          4'h1
`define SEL_PIN_TWO          4'h2
`define SEL_REF_CLOCK        4'h3
`define SEL_PWM_FIRST        4'h4
`define SEL_PWM_LAST         4'h7
`endif

// ---- include/carrier_pkg.sv ----
// Types shared by the carrier selector design files.
// Assumes carrier_params.svh is on the include path.
package carrier_pkg;
	typedef struct packed {
		logic       out_disable;
		logic       invert;
		logic       sync_enable;
		logic [3:0] source_select;
	} carrier_cfg_t;

	typedef struct packed {
		logic       pin_one;
		logic       pin_two;
		logic       ref_clock;
		logic [3:0] pwm;
	} carrier_src_t;

	typedef enum logic {
		CARRIER_LOW,
		CARRIER_HIGH
	} carrier_state_t;
endpackage

// ---- sim/carrier_source_model.sv ----
// Model of the carrier sources: each source is a distinct wave decoded from one free-running counter.
// Assumes the clk domain; freeze stalls every source at its level.
module carrier_source_model
	import carrier_pkg::*;
(
	input  wire logic                 clk,      // Clock.
	input  wire logic                 sys_rst,  // Async reset, high.
	input  wire logic                 freeze,   // Stall all sources.
	output carrier_pkg::carrier_src_t src_pins  // Carrier sources.
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [4:0] cnt_ff;
	always_ff @(posedge clk or posedge sys_rst)
		if (sys_rst)
			cnt_ff <= 5'h00;
		else if (!freeze)
			cnt_ff <= cnt_ff + 5'h01;
	// Order: pin one, pin two, reference clock, pwm four down to one.
	assign src_pins = {cnt_ff[1], cnt_ff[2], cnt_ff[0], cnt_ff[3] ^ cnt_ff[2],
		cnt_ff[4], cnt_ff[3], cnt_ff[2] & cnt_ff[1]};
endmodule

// ---- sim/tb_modulator_low_carrier_select.sv ----
// Self-checking bench of the low carrier selector.
// Assumes the source model drives the carrier pins.
module tb_modulator_low_carrier_select;
	timeunit 1ns;
	timeprecision 1ps;
	import carrier_pkg::*;
	logic         clk = 0;
	logic         sys_rst = 1;
	logic         reg_wr = 0;
	logic         reg_rd = 0;
	logic         mod_data = 0;
	logic         freeze = 0;
	logic         clk_en = 1;
	logic [1:0]   reg_addr = 2'h0;
	logic [7:0]   reg_wdata = 8'h00;
	logic [7:0]   reg_rdata;
	logic         low_pin_en;
	logic         high_pin_en;
	logic         mod_out;
	logic         on_high;
	logic         low_carrier;
	logic         high_carrier;
	carrier_src_t src_pins;
	carrier_src_t hist [4];
	int           fail_count = 0;
	int           total_checks = 0;
	always #12.5 clk = ~clk;
	// Source values seen at the last four edges; the carrier lags three, the stream four.
	always @(posedge clk)
		hist <= '{src_pins, hist[0], hist[1], hist[2]};
	carrier_source_model src_u (.clk(clk), .sys_rst(sys_rst), .freeze(freeze), .src_pins(src_pins));
	modulator_low_carrier_select dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .src_pins(src_pins), .mod_data(mod_data), .mod_out(mod_out),
		.low_pin_en(low_pin_en), .high_pin_en(high_pin_en), .low_carrier(low_carrier),
		.high_carrier(high_carrier), .on_high(on_high));
	task results;
		if (fail_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [1:0] a, input logic [7:0] exp);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		check(reg_rdata, exp);
	endtask
	function automatic logic pick(input logic [3:0] c, input carrier_src_t s);
		case (c)
			4'h1: return s.pin_one;
			4'h2: return s.pin_two;
			4'h3: return s.ref_clock;
			4'h4, 4'h5, 4'h6, 4'h7: return s.pwm[c[1:0]];
			default: return 1'b0;
		endcase
	endfunction
	task reg_check;
		rd(2'h3, 8'h00);
		wr(2'h0, 8'h80);
		wr(2'h3, 8'hff);
		rd(2'h3, 8'hef);
		check(8'(low_pin_en), 8'h00);
		wr(2'h3, 8'h01);
		repeat (3) @(posedge clk);
		@(negedge clk);
		check(8'(low_pin_en), 8'h01);
		wr(2'h2, 8'hff);
		rd(2'h2, 8'hef);
		check(8'(high_pin_en), 8'h00);
		wr(2'h1, 8'hff);
		rd(2'h1, 8'h8f);
	endtask
	task sel_check;
		for (int c = 0; c < 16; c++)
			for (int v = 0; v < 2; v++)
			begin
				wr(2'h3, {1'b0, v[0], 2'b00, c[3:0]});
				repeat (4) @(posedge clk);
				repeat (8)
				begin
					@(negedge clk);
					check(8'(low_carrier), 8'(pick(c[3:0], hist[2]) ^ v[0]));
					check(8'(mod_out), 8'(pick(c[3:0], hist[3]) ^ v[0]));
				end
			end
	endtask
	// Freezes the carrier high, requests a switch, then lets the carrier fall.
	task switch_check(input logic to_high, input logic sync);
		int n;
		wr(2'h3, {2'b00, sync, 5'h02});
		wr(2'h2, {2'b00, sync, 5'h02});
		for (n = 0; n < 40 && !(src_pins.pin_two === 1'b1 && src_pins.pin_one === 1'b0); n++)
			@(negedge clk);
		if (n == 40)
		begin
			check(8'(n), 8'h00);
			results;
		end
		@(posedge clk);
		freeze <= 1'b1;
		mod_data <= to_high;
		repeat (6) @(posedge clk);
		@(negedge clk);
		check(8'(on_high), 8'(sync ? !to_high : to_high));
		check(8'(high_carrier), 8'h01);
		check(8'(mod_out), 8'h01);
		@(posedge clk);
		freeze <= 1'b0;
		for (n = 0; n < 40 && on_high !== to_high; n++)
			@(negedge clk);
		check(8'(on_high), 8'(to_high));
		if (n == 40)
			results;
	endtask
	// Lowers the clock enable: the carrier must stand still and a write must be lost.
	task hold_check;
		logic held;
		wr(2'h3, 8'h01);
		repeat (4) @(posedge clk);
		clk_en <= 1'b0;
		@(negedge clk);
		held = low_carrier;
		wr(2'h3, 8'h40);
		repeat (3)
		begin
			@(negedge clk);
			check(8'(low_carrier), 8'(held));
		end
		@(posedge clk);
		clk_en <= 1'b1;
		rd(2'h3, 8'h01);
	endtask
	initial
	begin
		repeat (2) @(posedge clk);
		sys_rst <= 1'b0;
		reg_check;
		wr(2'h1, 8'h01);
		sel_check;
		rd(2'h0, 8'h88);
		hold_check;
		for (int s = 0; s < 2; s++)
		begin
			switch_check(1'b1, s[0]);
			switch_check(1'b0, s[0]);
		end
		results;
	end
endmodule

// ---- src/carrier_select.sv ----
// Carrier source multiplexer with polarity and pin-drive disable.
// Assumes synchronised sources on the clk domain.
`include "carrier_params.svh"
module carrier_select
	import carrier_pkg::*;
(
	input  wire logic                      clk,         // Clock.
	input  wire logic                      sys_rst,     // Async reset.
	input  wire logic                      clk_en,      // Clock enable.
	input  wire carrier_pkg::carrier_cfg_t cfg,         // Selection setup.
	input  wire carrier_pkg::carrier_src_t src,         // Sources.
	output logic                           carrier_ff,  // Conditioned carrier.
	output logic                           pin_en_ff    // Pin drive allowed.
);
	function automatic logic pick(input logic [3:0] sel, input carrier_src_t s);
		logic r;
		r = 1'b0;
		if (sel == `SEL_PIN_ONE)
			r = s.pin_one;
		else if (sel == `SEL_PIN_TWO)
			r = s.pin_two;
		else if (sel == `SEL_REF_CLOCK)
			r = s.ref_clock;
		else if (sel >= `SEL_PWM_FIRST && sel <= `SEL_PWM_LAST)
			r = s.pwm[sel[1:0]];
		return r;
	endfunction

	logic nxt_carrier;
	always_comb
	begin
		nxt_carrier = pick(cfg.source_select, src) ^ cfg.invert;
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			carrier_ff <= 1'b0;
			pin_en_ff  <= 1'b0;
		end
		else if (clk_en)
		begin
			carrier_ff <= nxt_carrier;
			pin_en_ff  <= ~cfg.out_disable;
		end
	end
endmodule

// ---- src/modulator_low_carrier_select.sv ----
// Carrier selection and low/high switching of a data signal modulator.
// Assumes external carrier pins asynchronous; register port on clk.
`include "carrier_params.svh"
// Summary of operation
// - Codes 1-7 route pins, refclock, PWM one-four.
// - Codes above seven connect no carrier.
// - Invert bit inverts selected low carrier.
// - Low sync waits low-carrier falling edge.
// - Unsynchronised switching may leave narrow pulses.
// - Out-disable bit blocks carrier pin drive.
// - Unimplemented bits read zero, ignore writes.
// - High sync waits high-carrier falling edge.
module modulator_low_carrier_select
	import carrier_pkg::*;
(
	input  wire logic                      clk,            // 40 MHz clock.
	input  wire logic                      sys_rst,        // Async reset, high.
	input  wire logic                      clk_en,         // Freezes state when low.
	input  wire logic [1:0]                reg_addr,       // Register index.
	input  wire logic [7:0]                reg_wdata,      // Write data.
	input  wire logic                      reg_wr,         // Write strobe.
	input  wire logic                      reg_rd,         // Read strobe.
	output logic [7:0]                     reg_rdata,      // Read data, next cycle.
	input  wire carrier_pkg::carrier_src_t src_pins,       // Carrier sources.
	input  wire logic                      mod_data,       // Modulation data level.
	output logic                           mod_out,        // Modulated stream.
	output logic                           low_pin_en,     // Low carrier pin drive.
	output logic                           high_pin_en,    // High carrier pin drive.
	output logic                           low_carrier,    // Conditioned low carrier.
	output logic                           high_carrier,   // Conditioned high carrier.
	output logic                           on_high         // High carrier in use.
);
	import carrier_pkg::*;

	logic [7:0]     low_reg_ff;
	logic [7:0]     high_reg_ff;
	logic [7:0]     ctl_reg_ff;
	logic [7:0]     src_reg_ff;
	logic [7:0]     rdata_ff;
	carrier_src_t   sync1_ff;
	carrier_src_t   sync2_ff;
	logic           data1_ff;
	logic           data2_ff;
	logic           low_c;
	logic           high_c;
	logic           low_prev_ff;
	logic           high_prev_ff;
	logic           low_pen;
	logic           high_pen;
	carrier_state_t state_ff;
	carrier_state_t nxt_state;
	logic           out_ff;
	logic           sel_data;
	carrier_cfg_t   low_cfg;
	carrier_cfg_t   high_cfg;

	function automatic carrier_cfg_t to_cfg(input logic [7:0] r);
		carrier_cfg_t c;
		c.out_disable   = r[`BIT_OUT_DISABLE];
		c.invert        = r[`BIT_INVERT];
		c.sync_enable   = r[`BIT_SYNC_ENABLE];
		c.source_select = r[3:0];
		return c;
	endfunction

	assign low_cfg  = to_cfg(low_reg_ff);
	assign high_cfg = to_cfg(high_reg_ff);

	// Registers; masks keep unimplemented bits at zero.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			low_reg_ff  <= `RST_REG;
			high_reg_ff <= `RST_REG;
			ctl_reg_ff  <= `RST_REG;
			src_reg_ff  <= `RST_REG;
		end
		else if (clk_en && reg_wr)
		begin
			unique case (reg_addr)
				`OFS_LOW_CARRIER:    low_reg_ff  <= reg_wdata & `MASK_CARRIER;
				`OFS_HIGH_CARRIER:   high_reg_ff <= reg_wdata & `MASK_CARRIER;
				`OFS_MOD_CONTROL:    ctl_reg_ff  <= reg_wdata & `MASK_CONTROL;
				`OFS_SOURCE_CONTROL: src_reg_ff  <= reg_wdata & `MASK_SOURCE;
			endcase
		end
	end

	// Read data; bit 3 of the control register reports the live output.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			rdata_ff <= 8'h00;
		else if (clk_en)
		begin
			if (reg_rd)
			begin
				unique case (reg_addr)
					`OFS_LOW_CARRIER:    rdata_ff <= low_reg_ff;
					`OFS_HIGH_CARRIER:   rdata_ff <= high_reg_ff;
					`OFS_MOD_CONTROL:    rdata_ff <= ctl_reg_ff | {4'h0, out_ff, 3'h0};
					`OFS_SOURCE_CONTROL: rdata_ff <= src_reg_ff;
				endcase
			end
			else
				rdata_ff <= 8'h00;
		end
	end
	assign reg_rdata = rdata_ff;

	// Two-stage synchronisers for external sources and data.
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			data1_ff <= 1'b0;
			data2_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			sync1_ff <= src_pins;
			sync2_ff <= sync1_ff;
			data1_ff <= mod_data;
			data2_ff <= data1_ff;
		end
	end

	carrier_select u_low (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.clk_en     (clk_en),
		.cfg        (low_cfg),
		.src        (sync2_ff),
		.carrier_ff (low_c),
		.pin_en_ff  (low_pen)
	);

	carrier_select u_high (
		.clk        (clk),
		.sys_rst    (sys_rst),
		.clk_en     (clk_en),
		.cfg        (high_cfg),
		.src        (sync2_ff),
		.carrier_ff (high_c),
		.pin_en_ff  (high_pen)
	);

	assign sel_data = ctl_reg_ff[`BIT_MOD_ENABLE] &
		((src_reg_ff[3:0] == 4'h0) ? ctl_reg_ff[`BIT_SW_MOD_BIT] : data2_ff);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			low_prev_ff  <= 1'b0;
			high_prev_ff <= 1'b0;
		end
		else if (clk_en)
		begin
			low_prev_ff  <= low_c;
			high_prev_ff <= high_c;
		end
	end

	// Switching; unsynchronised mode may chop carrier pulses by design.
	always_comb
	begin
		nxt_state = state_ff;
		unique case (state_ff)
			CARRIER_LOW:
				if (sel_data && (!low_cfg.sync_enable || (low_prev_ff && !low_c)))
					nxt_state = CARRIER_HIGH;
			CARRIER_HIGH:
				if (!sel_data && (!high_cfg.sync_enable || (high_prev_ff && !high_c)))
					nxt_state = CARRIER_LOW;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state_ff <= CARRIER_LOW;
			out_ff   <= 1'b0;
		end
		else if (clk_en)
		begin
			state_ff <= nxt_state;
			out_ff   <= (nxt_state == CARRIER_HIGH) ? high_c : low_c;
		end
	end

	assign mod_out      = out_ff;
	assign low_pin_en   = low_pen;
	assign high_pin_en  = high_pen;
	assign low_carrier  = low_c;
	assign high_carrier = high_c;
	assign on_high      = (state_ff == CARRIER_HIGH);

	low_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && $past(clk_en) && state_ff == CARRIER_LOW && low_cfg.sync_enable && !(low_prev_ff && !low_c)
		|=> state_ff == CARRIER_LOW)
		else $error("low to high switch without low carrier falling edge");
	high_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state_ff == CARRIER_HIGH && high_cfg.sync_enable && !(high_prev_ff && !high_c)
		|=> state_ff == CARRIER_HIGH)
		else $error("high to low switch without high carrier falling edge");
	no_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state_ff == CARRIER_LOW && !low_cfg.sync_enable && sel_data |=> state_ff == CARRIER_HIGH)
		else $error("unsynchronised switch delayed");
	reserved_sel_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && low_cfg.source_select > `SEL_PWM_LAST |=> low_c == $past(low_cfg.invert))
		else $error("reserved code routed a carrier");
	invert_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && low_cfg.source_select == `SEL_PIN_ONE |=> low_c == ($past(sync2_ff.pin_one) ^ $past(low_cfg.invert)))
		else $error("low carrier polarity wrong");
	pwm_route_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && low_cfg.source_select == `SEL_PWM_LAST |=> low_c == ($past(sync2_ff.pwm[3]) ^ $past(low_cfg.invert)))
		else $error("pwm four not routed");
	out_dis_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && low_cfg.out_disable |=> !low_pin_en)
		else $error("pin driven while disabled");
	unimpl_a: assert property (@(posedge clk) disable iff (sys_rst)
		reg_rd && reg_addr == `OFS_LOW_CARRIER && clk_en |=> reg_rdata[4] == 1'b0)
		else $error("unimplemented bit read as one");
	sync_hold_c: cover property (@(posedge clk) state_ff == CARRIER_LOW && low_cfg.sync_enable ##1 on_high);
	back_low_c: cover property (@(posedge clk) on_high ##1 !on_high);
	reserved_c: cover property (@(posedge clk) low_cfg.source_select > `SEL_PWM_LAST && sel_data);
	pwm_one_c: cover property (@(posedge clk) low_cfg.source_select == `SEL_PWM_FIRST && low_c);
	no_sync_c: cover property (@(posedge clk) !low_cfg.sync_enable && !on_high ##1 on_high);

	// Pin two, reference clock and pwm one codes; each carrier lands one edge after its synchronised sample.
	pin_two_route_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && low_cfg.source_select == `SEL_PIN_TWO
		|=> low_c == ($past(sync2_ff.pin_two) ^ $past(low_cfg.invert)))
		else $error("pin two not routed");

	ref_route_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && low_cfg.source_select == `SEL_REF_CLOCK
		|=> low_c == ($past(sync2_ff.ref_clock) ^ $past(low_cfg.invert)))
		else $error("reference clock not routed");

	pwm_one_route_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && low_cfg.source_select == `SEL_PWM_FIRST
		|=> low_c == ($past(sync2_ff.pwm[0]) ^ $past(low_cfg.invert)))
		else $error("pwm one not routed");

	// The high path shares the selector, so a reserved code must also leave it unconnected.
	high_reserved_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && high_cfg.source_select > `SEL_PWM_LAST
		|=> high_c == $past(high_cfg.invert))
		else $error("reserved high code routed a carrier");

	// Pin drive follows the disable bits in both directions.
	pin_enable_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && !low_cfg.out_disable |=> low_pin_en)
		else $error("pin not driven while enabled");

	high_out_dis_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && high_cfg.out_disable |=> !high_pin_en)
		else $error("high pin driven while disabled");

	// A request that meets its carrier falling edge must switch at once.
	sync_switch_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state_ff == CARRIER_LOW && low_cfg.sync_enable && sel_data && low_prev_ff && !low_c
		|=> state_ff == CARRIER_HIGH)
		else $error("low to high switch missed its falling edge");

	high_sync_switch_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state_ff == CARRIER_HIGH && high_cfg.sync_enable && !sel_data && high_prev_ff && !high_c
		|=> state_ff == CARRIER_LOW)
		else $error("high to low switch missed its falling edge");

	high_no_sync_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state_ff == CARRIER_HIGH && !high_cfg.sync_enable && !sel_data |=> state_ff == CARRIER_LOW)
		else $error("unsynchronised high to low switch delayed");

	// Without a change of data level the carrier in use is kept.
	idle_low_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state_ff == CARRIER_LOW && !sel_data |=> state_ff == CARRIER_LOW)
		else $error("switch to high carrier without data");

	idle_high_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state_ff == CARRIER_HIGH && sel_data |=> state_ff == CARRIER_HIGH)
		else $error("switch to low carrier without data");

	// The stream carries the carrier in use, possibly chopped at a switch.
	stream_low_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state_ff == CARRIER_LOW && !sel_data |=> mod_out == $past(low_c))
		else $error("stream does not follow low carrier");

	stream_high_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && state_ff == CARRIER_HIGH && sel_data |=> mod_out == $past(high_c))
		else $error("stream does not follow high carrier");

	// Reserved bits of the other registers read as zero.
	source_unimpl_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && reg_rd && reg_addr == `OFS_SOURCE_CONTROL |=> reg_rdata[6:4] == 3'h0)
		else $error("unimplemented source bit read as one");

	control_unimpl_a: assert property (@(posedge clk) disable iff (sys_rst)
		clk_en && reg_rd && reg_addr == `OFS_MOD_CONTROL |=> reg_rdata[2:1] == 2'h0)
		else $error("unimplemented control bit read as one");
endmodule
